// ---- hw/rstpt_fifo.sv ----
/*
  Small FIFO with a registered read stage and registered write ready.
  Assumes DEPTH of at least two; read data always leave from a flip-flop.
*/
module rstpt_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clock, // Core clock
  input wire logic rst_n, // Synchronous reset, active low
  rstpt_stream_if.snk wr, // Filling side
  rstpt_stream_if.src rd  // Draining side
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic rdy_q;
  logic ov_q;
  logic [WIDTH-1:0] od_q;
  logic push;
  logic pop;

  // Ready is a flop, so a word is never offered to a full array
  assign push = wr.valid & rdy_q;
  assign pop = (cnt_q != '0) & (~ov_q | rd.ready);
  assign wr.ready = rdy_q;
  assign rd.valid = ov_q;
  assign rd.data = od_q;

  // Occupancy of the array, the read stage not counted
  always_comb begin
    cnt_d = cnt_q;
    if (push & ~pop) begin
      cnt_d = cnt_q + CW'(1);
    end else if (pop & ~push) begin
      cnt_d = cnt_q - CW'(1);
    end
  end

  // Storage needs no reset
  always_ff @(posedge clock) begin
    if (push) begin
      mem_q[wp_q] <= wr.data;
    end
  end

  // Pointers, count and write ready
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      rdy_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      rdy_q <= (cnt_d != CW'(DEPTH));
      if (push) begin
        wp_q <= (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + AW'(1);
      end
      if (pop) begin
        rp_q <= (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + AW'(1);
      end
    end
  end

  // Registered read stage
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ov_q <= 1'b0;
      od_q <= '0;
    end else if (pop) begin
      ov_q <= 1'b1;
      od_q <= mem_q[rp_q];
    end else if (rd.ready) begin
      ov_q <= 1'b0;
    end
  end
endmodule

// ---- hw/rstpt_pkg.sv ----
/*
  Shared constants and types for the port state control and tail tag framer.
  Assumes a single 250 MHz core clock and byte-wide frame streams without FCS.
*/
package rstpt_pkg;
  // Port count and buffering
  localparam int NPORT = 3;
  localparam int FIFO_DEPTH = 8;
  localparam int BYTE_W = 8;

  // Tail tag field positions, frames from the host
  localparam int TAG_DEST_LO = 1;
  localparam int TAG_QUEUE_LO = 4;
  localparam int TAG_FORCE_BIT = 6;
  localparam int TAG_LOOKUP_BIT = 7;

  // Destination codes in tag bits three to one
  localparam logic [2:0] DEST_P1 = 3'h1;
  localparam logic [2:0] DEST_P2 = 3'h2;
  localparam logic [2:0] DEST_P3 = 3'h4;
  localparam logic [2:0] DEST_ALL = 3'h7;
  localparam logic [2:0] DEST_NONE = 3'h0;

  // Source code is port index plus this offset; zero is reserved
  localparam logic [1:0] SRC_CODE_BASE = 2'h1;

  // Frame check sequence
  localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_POLY = 32'hEDB88320;

  // Layout of a word in the host ingress buffer
  localparam int W_DATA_LO = 0;
  localparam int W_LAST = 8;
  localparam int W_DEST_LO = 9;
  localparam int W_QUEUE_LO = 12;
  localparam int W_LOOKUP = 14;
  localparam int W_FCS_LO = 15;
  localparam int WORD_W = 47;

  typedef enum logic [1:0] {PS_DISCARD, PS_LEARN, PS_FORWARD} rstpt_pstate_t;
  typedef enum logic [1:0] {EG_SOP, EG_MID, EG_TAG} rstpt_egst_t;

  // One byte of reflected CRC-32
  function automatic logic [31:0] rstpt_crc8(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c ^ {24'h000000, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction
endpackage

// ---- hw/rstpt_stream_if.sv ----
/*
  Valid/ready word stream between the framer and its buffer.
  Assumes both ends share the core clock.
*/
interface rstpt_stream_if #(parameter int WIDTH = 8) ();
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ---- hw/rstpt_top.sv ----
/*
  Per-port spanning tree state control and host port tail tag framing.
  Assumes frame streams carry no FCS; the block recomputes it and hands it
  out beside the last byte. Control inputs come from logic on the same clock.
*/
// Notes on behaviour
// - Tx off, rx off, learning disabled: port discards and learns nothing.
// - A discarding port may still pass override-matched frames up to the host.
// - Learning disabled plus both flush bits: flush port's dynamic and static entries.
// - Learning disable clear, tx/rx off: learn, pass only host traffic.
// - Tx and rx on, learning disable clear: forward normally and learn.
// - In learning and forwarding, host frames go where the tail tag directs.
// - One-byte tail tag only on host port and only when tag enable set.
// - Host tag bits 3:1 pick port 1, 2, 3 or all; 000 reserved.
// - Host tag bits 5:4 values zero to three pick egress queue zero to three.
// - Host tag bit 6 forces delivery to the ports in bits 3:1.
// - Host tag bit 7 ignores bits 6:0 and uses normal address lookup.
// - Frames to host report ingress port in bits 1:0; 00 reserved.
module rstpt_top (
  input wire logic clock, // Core clock, 250 MHz
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic [rstpt_pkg::NPORT-1:0] tx_en, // Per-port transmit enable
  input wire logic [rstpt_pkg::NPORT-1:0] rx_en, // Per-port receive enable
  input wire logic [rstpt_pkg::NPORT-1:0] learn_dis, // Per-port learning disable
  input wire logic flush_dyn, // Flush dynamic table control
  input wire logic flush_sta, // Flush static table control
  input wire logic tail_tag_en, // Tail tag mode on host port
  output rstpt_pkg::rstpt_pstate_t port_state [rstpt_pkg::NPORT], // Decoded state
  output logic [rstpt_pkg::NPORT-1:0] learn_en, // Source learning allowed
  output logic [rstpt_pkg::NPORT-1:0] user_fwd, // User traffic allowed
  output logic [rstpt_pkg::NPORT-1:0] dyn_flush, // Dynamic flush pulse
  output logic [rstpt_pkg::NPORT-1:0] sta_flush, // Static flush pulse
  input wire logic hin_valid, // Host frame byte valid
  input wire logic [7:0] hin_data, // Host frame byte
  input wire logic hin_last, // Host frame last byte
  output logic hin_ready, // Host frame byte taken
  output logic fab_valid, // Fabric byte valid
  output logic [7:0] fab_data, // Fabric byte, tag stripped
  output logic fab_last, // Fabric last byte
  output logic [2:0] fab_dest, // Destination ports, valid with last
  output logic [1:0] fab_queue, // Egress queue, valid with last
  output logic fab_lookup, // Use address lookup, valid with last
  output logic [31:0] fab_fcs, // New FCS, valid with last
  input wire logic fab_ready, // Fabric takes byte
  input wire logic sw_valid, // Host-bound byte valid
  input wire logic [7:0] sw_data, // Host-bound byte
  input wire logic sw_last, // Host-bound last byte
  input wire logic [1:0] sw_src, // Ingress port index, 0 to 2
  input wire logic sw_ovr, // Static override match
  output logic sw_ready, // Host-bound byte taken
  output logic hout_valid, // Byte to host valid
  output logic [7:0] hout_data, // Byte to host
  output logic hout_last, // Last byte to host
  output logic [31:0] hout_fcs // FCS to host, valid with last
);
  localparam int NP = rstpt_pkg::NPORT;
  localparam int WW = rstpt_pkg::WORD_W;

  rstpt_pkg::rstpt_pstate_t pst_q [NP];
  logic [NP-1:0] learn_q;
  logic [NP-1:0] ufwd_q;
  logic [NP-1:0] dflush_q;
  logic [NP-1:0] sflush_q;
  logic [NP-1:0] disc;
  logic flush_both_q;

  // Per-port state decode; odd combinations fall back to discarding
  for (genvar i = 0; i < NP; i++) begin : g_port
    always_ff @(posedge clock) begin
      if (!rst_n) begin
        pst_q[i] <= rstpt_pkg::PS_DISCARD;
        learn_q[i] <= 1'b0;
        ufwd_q[i] <= 1'b0;
      end else if (tx_en[i] & rx_en[i] & ~learn_dis[i]) begin
        pst_q[i] <= rstpt_pkg::PS_FORWARD;
        learn_q[i] <= 1'b1;
        ufwd_q[i] <= 1'b1;
      end else if (~tx_en[i] & ~rx_en[i] & ~learn_dis[i]) begin
        pst_q[i] <= rstpt_pkg::PS_LEARN;
        learn_q[i] <= 1'b1;
        ufwd_q[i] <= 1'b0;
      end else begin
        pst_q[i] <= rstpt_pkg::PS_DISCARD;
        learn_q[i] <= 1'b0;
        ufwd_q[i] <= 1'b0;
      end
    end

    // Flush fires once when both bits come up with learning off
    always_ff @(posedge clock) begin
      if (!rst_n) begin
        dflush_q[i] <= 1'b0;
        sflush_q[i] <= 1'b0;
      end else begin
        dflush_q[i] <= flush_dyn & flush_sta & ~flush_both_q & learn_dis[i];
        sflush_q[i] <= flush_dyn & flush_sta & ~flush_both_q & learn_dis[i];
      end
    end

    assign disc[i] = (pst_q[i] == rstpt_pkg::PS_DISCARD);
    assign port_state[i] = pst_q[i];

    a_disc_quiet: assert property (@(posedge clock) disable iff (!rst_n)
      disc[i] |-> !learn_q[i] && !ufwd_q[i]) else $error("discarding port learns or forwards");
    a_learn_only: assert property (@(posedge clock) disable iff (!rst_n)
      (rst_n && !tx_en[i] && !rx_en[i] && !learn_dis[i]) |=> learn_q[i] && !ufwd_q[i])
      else $error("learning state wrong");
    a_fwd_full: assert property (@(posedge clock) disable iff (!rst_n)
      (rst_n && tx_en[i] && rx_en[i] && !learn_dis[i]) |=> learn_q[i] && ufwd_q[i])
      else $error("forwarding state wrong");
    a_flush_pulse: assert property (@(posedge clock) disable iff (!rst_n)
      (flush_dyn && flush_sta && !flush_both_q && learn_dis[i])
      |=> dflush_q[i] && sflush_q[i] ##1 !dflush_q[i]) else $error("flush pulse wrong");
  end

  // Edge memory for the flush controls
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      flush_both_q <= 1'b0;
    end else begin
      flush_both_q <= flush_dyn & flush_sta;
    end
  end

  assign learn_en = learn_q;
  assign user_fwd = ufwd_q;
  assign dyn_flush = dflush_q;
  assign sta_flush = sflush_q;

  // Host to fabric: strip tag, decode it, buffer the bytes
  rstpt_stream_if #(.WIDTH(WW)) hbuf_wr ();
  rstpt_stream_if #(.WIDTH(WW)) hbuf_rd ();

  logic in_sop_q;
  logic in_tte_q;
  logic hold_v_q;
  logic [7:0] hold_q;
  logic [31:0] icrc_q;
  logic in_acc;
  logic in_tte;
  logic in_push;
  logic [7:0] in_byte;
  logic [31:0] icrc_next;
  logic [2:0] tag_dest;
  logic [2:0] in_dest;
  logic [1:0] in_queue;
  logic in_lookup;

  assign in_acc = hin_valid & hbuf_wr.ready;
  // Mode is frozen at frame start so a toggle cannot split a frame
  assign in_tte = in_sop_q ? tail_tag_en : in_tte_q;
  assign in_push = in_acc & (~in_tte | hold_v_q);
  assign in_byte = in_tte ? hold_q : hin_data;
  assign icrc_next = rstpt_pkg::rstpt_crc8(icrc_q, in_byte);

  // Destination decode; reserved and unlisted codes name no port
  always_comb begin
    case (hin_data[rstpt_pkg::TAG_DEST_LO +: 3])
      rstpt_pkg::DEST_P1: tag_dest = rstpt_pkg::DEST_P1;
      rstpt_pkg::DEST_P2: tag_dest = rstpt_pkg::DEST_P2;
      rstpt_pkg::DEST_P3: tag_dest = rstpt_pkg::DEST_P3;
      rstpt_pkg::DEST_ALL: tag_dest = rstpt_pkg::DEST_ALL;
      default: tag_dest = rstpt_pkg::DEST_NONE;
    endcase
  end

  // Metadata carried by the last word of each frame
  always_comb begin
    in_dest = rstpt_pkg::DEST_NONE;
    in_queue = 2'h0;
    in_lookup = 1'b1;
    if (in_tte & hin_last & ~hin_data[rstpt_pkg::TAG_LOOKUP_BIT]) begin
      in_lookup = 1'b0;
      in_queue = hin_data[rstpt_pkg::TAG_QUEUE_LO +: 2];
      if (hin_data[rstpt_pkg::TAG_FORCE_BIT]) begin
        in_dest = tag_dest;
      end else begin
        in_dest = tag_dest & ~disc;
      end
    end
  end

  assign hbuf_wr.valid = in_push;
  assign hbuf_wr.data = {~icrc_next, in_lookup, in_queue, in_dest, hin_last, in_byte};
  assign hin_ready = hbuf_wr.ready;

  // Frame tracking, held byte and running FCS on the ingress side
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      in_sop_q <= 1'b1;
      in_tte_q <= 1'b0;
      hold_v_q <= 1'b0;
      hold_q <= 8'h00;
      icrc_q <= rstpt_pkg::CRC_INIT;
    end else begin
      if (in_acc) begin
        in_sop_q <= hin_last;
        in_tte_q <= in_tte;
        hold_v_q <= in_tte & ~hin_last;
        hold_q <= hin_data;
      end
      if (in_push) begin
        icrc_q <= hin_last ? rstpt_pkg::CRC_INIT : icrc_next;
      end
    end
  end

  a_tag_lookup: assert property (@(posedge clock) disable iff (!rst_n)
    (in_push && in_tte && hin_last && hin_data[7])
    |-> hbuf_wr.data[rstpt_pkg::W_LOOKUP] && hbuf_wr.data[11:9] == 3'h0)
    else $error("lookup tag not honoured");
  a_tag_force: assert property (@(posedge clock) disable iff (!rst_n)
    (in_push && in_tte && hin_last && hin_data[7:6] == 2'h1 && hin_data[3:1] == 3'h7)
    |-> hbuf_wr.data[11:9] == 3'h7 && hbuf_wr.data[13:12] == hin_data[5:4])
    else $error("forced tag not honoured");
  a_tag_strip: assert property (@(posedge clock) disable iff (!rst_n)
    (in_acc && in_tte && hin_last && !hold_v_q) |-> !in_push)
    else $error("tag byte reached fabric");

  rstpt_fifo #(.WIDTH(WW), .DEPTH(rstpt_pkg::FIFO_DEPTH)) u_hbuf (
    .clock(clock),
    .rst_n(rst_n),
    .wr(hbuf_wr),
    .rd(hbuf_rd)
  );

  assign hbuf_rd.ready = fab_ready;
  assign fab_valid = hbuf_rd.valid;
  assign fab_data = hbuf_rd.data[rstpt_pkg::W_DATA_LO +: 8];
  assign fab_last = hbuf_rd.data[rstpt_pkg::W_LAST];
  assign fab_dest = hbuf_rd.data[rstpt_pkg::W_DEST_LO +: 3];
  assign fab_queue = hbuf_rd.data[rstpt_pkg::W_QUEUE_LO +: 2];
  assign fab_lookup = hbuf_rd.data[rstpt_pkg::W_LOOKUP];
  assign fab_fcs = hbuf_rd.data[rstpt_pkg::W_FCS_LO +: 32];

  // Fabric to host: filter by port state, append tag, recompute FCS
  rstpt_pkg::rstpt_egst_t eg_q;
  logic sw_rdy_q;
  logic eg_pass_q;
  logic eg_tte_q;
  logic [1:0] src_q;
  logic ov_q;
  logic [7:0] od_q;
  logic ol_q;
  logic [31:0] ofcs_q;
  logic [31:0] ecrc_q;
  logic sw_acc;
  logic src_ok;
  logic cur_pass;
  logic cur_tte;
  logic emit;
  logic emit_last;
  logic [7:0] emit_byte;
  logic [31:0] ecrc_next;

  assign sw_acc = sw_valid & sw_rdy_q;
  assign src_ok = (sw_src < 2'(NP));
  // Discarding ports still reach the host on an override match
  assign cur_pass = (eg_q == rstpt_pkg::EG_SOP) ? (src_ok & (~disc[sw_src] | sw_ovr)) : eg_pass_q;
  assign cur_tte = (eg_q == rstpt_pkg::EG_SOP) ? tail_tag_en : eg_tte_q;
  assign emit = (sw_acc & cur_pass) | (eg_q == rstpt_pkg::EG_TAG);
  assign emit_last = (eg_q == rstpt_pkg::EG_TAG) | (sw_last & ~cur_tte);
  assign emit_byte = (eg_q == rstpt_pkg::EG_TAG) ? {6'h00, src_q + rstpt_pkg::SRC_CODE_BASE} : sw_data;
  assign ecrc_next = rstpt_pkg::rstpt_crc8(ecrc_q, emit_byte);

  // Frame sequencing; input stalls for the one tag cycle
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      eg_q <= rstpt_pkg::EG_SOP;
      sw_rdy_q <= 1'b0;
      eg_pass_q <= 1'b0;
      eg_tte_q <= 1'b0;
      src_q <= 2'h0;
    end else begin
      sw_rdy_q <= ~(sw_acc & sw_last & cur_tte & cur_pass);
      case (eg_q)
        rstpt_pkg::EG_SOP, rstpt_pkg::EG_MID: begin
          if (sw_acc) begin
            if (eg_q == rstpt_pkg::EG_SOP) begin
              src_q <= sw_src;
            end
            eg_pass_q <= cur_pass;
            eg_tte_q <= cur_tte;
            if (!sw_last) begin
              eg_q <= rstpt_pkg::EG_MID;
            end else if (cur_tte & cur_pass) begin
              eg_q <= rstpt_pkg::EG_TAG;
            end else begin
              eg_q <= rstpt_pkg::EG_SOP;
            end
          end
        end
        rstpt_pkg::EG_TAG: eg_q <= rstpt_pkg::EG_SOP;
        default: eg_q <= rstpt_pkg::EG_SOP;
      endcase
    end
  end

  // Registered byte stream toward the host with running FCS
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ov_q <= 1'b0;
      od_q <= 8'h00;
      ol_q <= 1'b0;
      ofcs_q <= 32'h00000000;
      ecrc_q <= rstpt_pkg::CRC_INIT;
    end else begin
      ov_q <= emit;
      if (emit) begin
        od_q <= emit_byte;
        ol_q <= emit_last;
        ecrc_q <= emit_last ? rstpt_pkg::CRC_INIT : ecrc_next;
        if (emit_last) begin
          ofcs_q <= ~ecrc_next;
        end
      end
    end
  end

  assign sw_ready = sw_rdy_q;
  assign hout_valid = ov_q;
  assign hout_data = od_q;
  assign hout_last = ol_q;
  assign hout_fcs = ofcs_q;

  a_disc_drop: assert property (@(posedge clock) disable iff (!rst_n)
    (sw_acc && eg_q == rstpt_pkg::EG_SOP && src_ok && disc[sw_src] && !sw_ovr) |=> !hout_valid)
    else $error("discarding port reached host");
  a_tag_append: assert property (@(posedge clock) disable iff (!rst_n)
    (sw_acc && sw_last && cur_tte && cur_pass)
    |=> hout_valid && !hout_last && !sw_ready
    ##1 hout_valid && hout_last && hout_data == {6'h00, src_q + 2'h1})
    else $error("tail tag not appended");
  a_tag_off: assert property (@(posedge clock) disable iff (!rst_n)
    (sw_acc && sw_last && !cur_tte && cur_pass) |=> hout_valid && hout_last && sw_ready)
    else $error("tag sent while disabled");
endmodule

// ---- testbench/rstpt_host_model.sv ----
/*
  Host processor model on the host port: sends tagged frames, keeps frames sent up.
  Assumes the core clock; drives its lines by non-blocking assignment at the rising edge.
*/
module rstpt_host_model (
  input wire logic clock, // Core clock
  output logic hin_valid, // Byte valid
  output logic [7:0] hin_data, // Byte
  output logic hin_last, // Last byte
  input wire logic hin_ready, // Byte taken
  input wire logic hout_valid, // Byte up valid
  input wire logic [7:0] hout_data, // Byte up
  input wire logic hout_last, // Last byte up
  input wire logic [31:0] hout_fcs // FCS with last
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [40:0] rx_q[$];
  int stalls;

  // Idle lines
  initial begin
    hin_valid = 1'b0;
    hin_data = 8'hA5;
    hin_last = 1'b0;
    stalls = 0;
  end

  // Frame held byte by byte until taken; released data inverted so nothing stale looks valid
  task automatic send(input logic [7:0] fr[$]);
    int n;
    @(posedge clock);
    foreach (fr[i]) begin
      hin_valid <= 1'b1;
      hin_data <= fr[i];
      hin_last <= (i == fr.size() - 1);
      n = 0;
      do begin
        @(posedge clock);
        n++;
      end while (hin_ready !== 1'b1 && n < 200);
      if (n >= 200) stalls++;
    end
    hin_valid <= 1'b0;
    hin_data <= ~hin_data;
    hin_last <= 1'b0;
  endtask

  // Streams counting bytes, never last, for cyc cycles; n returns how many were taken
  task automatic fill(input int cyc, output int n);
    n = 0;
    @(posedge clock);
    hin_valid <= 1'b1;
    hin_data <= 8'h00;
    repeat (cyc) begin
      @(posedge clock);
      if (hin_ready === 1'b1) begin
        n++;
        hin_data <= 8'(n);
      end
    end
    hin_valid <= 1'b0;
  endtask

  // Every byte sent up is kept; the bench judges the frames
  always @(posedge clock) begin
    if (hout_valid === 1'b1) rx_q.push_back({hout_fcs, hout_last, hout_data});
  end
endmodule

// ---- testbench/test_rstpt_top.sv ----
/*
  Self-checking bench for the port state control and tail tag framer.
  Assumes the host model beside it; expectations come from queues built here.
*/
module test_rstpt_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, rst_n, flush_dyn, flush_sta, tail_tag_en, fab_hold;
  logic [2:0] tx_en, rx_en, learn_dis, learn_en, user_fwd, dyn_flush, sta_flush, fab_dest;
  rstpt_pkg::rstpt_pstate_t port_state [rstpt_pkg::NPORT];
  logic hin_valid, hin_last, hin_ready, fab_valid, fab_last, fab_lookup, fab_ready;
  logic sw_valid, sw_last, sw_ovr, sw_ready, hout_valid, hout_last;
  logic [7:0] hin_data, fab_data, sw_data, hout_data;
  logic [1:0] fab_queue, sw_src;
  logic [31:0] fab_fcs, hout_fcs, crc_run;
  logic [46:0] fab_q[$];
  logic [46:0] fx;
  logic [2:0] codes [6] = '{3'h1, 3'h2, 3'h4, 3'h7, 3'h0, 3'h5};
  int errors, tests_run;

  rstpt_top dut (.clock(clock), .rst_n(rst_n), .tx_en(tx_en), .rx_en(rx_en), .learn_dis(learn_dis),
    .flush_dyn(flush_dyn), .flush_sta(flush_sta), .tail_tag_en(tail_tag_en), .port_state(port_state),
    .learn_en(learn_en), .user_fwd(user_fwd), .dyn_flush(dyn_flush), .sta_flush(sta_flush),
    .hin_valid(hin_valid), .hin_data(hin_data), .hin_last(hin_last), .hin_ready(hin_ready),
    .fab_valid(fab_valid), .fab_data(fab_data), .fab_last(fab_last), .fab_dest(fab_dest),
    .fab_queue(fab_queue), .fab_lookup(fab_lookup), .fab_fcs(fab_fcs), .fab_ready(fab_ready),
    .sw_valid(sw_valid), .sw_data(sw_data), .sw_last(sw_last), .sw_src(sw_src), .sw_ovr(sw_ovr),
    .sw_ready(sw_ready), .hout_valid(hout_valid), .hout_data(hout_data), .hout_last(hout_last),
    .hout_fcs(hout_fcs));

  rstpt_host_model host (.clock(clock), .hin_valid(hin_valid), .hin_data(hin_data), .hin_last(hin_last),
    .hin_ready(hin_ready), .hout_valid(hout_valid), .hout_data(hout_data), .hout_last(hout_last),
    .hout_fcs(hout_fcs));

  // Clock
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // Fabric stalls at random, or fully while the buffer fills
  always @(posedge clock) fab_ready <= !fab_hold && ($urandom_range(3) != 0);

  // Each fabric byte against the oldest expectation; meta only with last
  always @(posedge clock) begin
    if (fab_valid === 1'b1 && fab_ready === 1'b1) begin
      fx = (fab_q.size() > 0) ? fab_q.pop_front() : '1;
      chk({fab_last, fab_data}, fx[8:0], "fabric byte");
      if (fx[8]) chk({fab_fcs, fab_lookup, fab_queue, fab_dest}, fx[46:9], "fabric meta");
    end
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic timeout(input string what);
    errors++;
    $display("CHECK FAILED at %0t: no progress on %s", $time, what);
    stop_test();
  endtask

  function automatic logic [31:0] crc_b(input logic [31:0] c, input logic [7:0] d);
    c = c ^ {24'h000000, d};
    repeat (8) c = c[0] ? ((c >> 1) ^ rstpt_pkg::CRC_POLY) : (c >> 1);
    return c;
  endfunction

  // Ports that are not discarding
  function automatic logic [2:0] live();
    return ~learn_dis & ~(tx_en ^ rx_en);
  endfunction

  task automatic cfg(input logic [8:0] v);
    rstpt_pkg::rstpt_pstate_t ps;
    @(posedge clock);
    {tx_en, rx_en, learn_dis} <= v;
    repeat (2) @(posedge clock);
    #1;
    for (int i = 0; i < 3; i++) begin
      ps = (tx_en[i] & rx_en[i] & !learn_dis[i]) ? rstpt_pkg::PS_FORWARD :
        (live() >> i) & 3'h1 ? rstpt_pkg::PS_LEARN : rstpt_pkg::PS_DISCARD;
      chk(port_state[i], ps, "port state");
    end
    chk(learn_en, live(), "learning");
    chk(user_fwd, tx_en & rx_en & ~learn_dis, "user traffic");
  endtask

  task automatic host_frame(input int n, input logic [7:0] tag);
    logic [7:0] fr[$];
    logic [5:0] m;
    logic [2:0] d;
    d = (tag[3:1] inside {3'h1, 3'h2, 3'h4, 3'h7}) ? tag[3:1] : 3'h0;
    if (!tag[6]) d = d & live();
    m = (tail_tag_en && !tag[7]) ? {1'b0, tag[5:4], d} : 6'h20;
    for (int i = 0; i < n; i++) begin
      fr.push_back(8'($urandom));
      crc_run = crc_b(crc_run, fr[i]);
      fab_q.push_back({~crc_run, m, i == n - 1, fr[i]});
    end
    crc_run = rstpt_pkg::CRC_INIT;
    if (tail_tag_en) fr.push_back(tag);
    host.send(fr);
    if (host.stalls != 0) timeout("host port");
  endtask

  task automatic sw_frame(input logic [1:0] s, input logic ovr, input int n);
    logic [40:0] ex[$];
    logic [40:0] e, r;
    logic [31:0] c;
    logic [7:0] b;
    logic pass;
    int k;
    c = rstpt_pkg::CRC_INIT;
    pass = (s != 2'h3) && (ovr || ((live() >> s) & 3'h1) != 3'h0);
    for (int i = 0; i < n; i++) begin
      b = 8'($urandom);
      c = crc_b(c, b);
      ex.push_back({~c, !tail_tag_en && i == n - 1, b});
      sw_valid <= 1'b1;
      sw_data <= b;
      sw_last <= (i == n - 1);
      sw_src <= s;
      sw_ovr <= ovr;
      k = 0;
      do begin
        @(posedge clock);
        k++;
      end while (sw_ready !== 1'b1 && k < 200);
      if (k >= 200) timeout("switch side");
    end
    sw_valid <= 1'b0;
    sw_data <= ~b;
    b = {6'h00, s + 2'h1};
    c = crc_b(c, b);
    if (tail_tag_en) ex.push_back({~c, 1'b1, b});
    repeat (6) @(posedge clock);
    if (!pass) ex.delete();
    chk(host.rx_q.size(), ex.size(), "bytes to host");
    while (ex.size() > 0 && host.rx_q.size() > 0) begin
      e = ex.pop_front();
      r = host.rx_q.pop_front();
      chk(r[8:0], e[8:0], "byte to host");
      if (e[8]) chk(r[40:9], e[40:9], "fcs to host");
    end
    host.rx_q.delete();
  endtask

  task automatic settle();
    int k;
    k = 0;
    while ((fab_q.size() > 0 || fab_valid !== 1'b0) && k < 500) begin
      @(posedge clock);
      k++;
    end
    if (k >= 500) timeout("fabric side");
  endtask

  // Cuts a hang short
  initial begin
    #200000;
    timeout("whole run");
  end

  // Main sequence
  initial begin
    int k;
    void'($urandom(65648));
    {tx_en, rx_en, learn_dis, flush_dyn, flush_sta, tail_tag_en, fab_hold} = '0;
    {sw_valid, sw_data, sw_last, sw_src, sw_ovr} = '0;
    crc_run = rstpt_pkg::CRC_INIT;
    rst_n = 1'b0;
    @(posedge clock);
    #1;
    chk({learn_en, user_fwd, hin_ready, sw_ready}, 8'h00, "reset outputs");
    chk(port_state[1], rstpt_pkg::PS_DISCARD, "reset state");
    @(posedge clock);
    rst_n <= 1'b1;
    repeat (2) @(posedge clock);
    for (int v = 0; v < 8; v++) cfg({{3{v[2]}}, {3{v[1]}}, {3{v[0]}}});
    repeat (6) cfg(9'($urandom));
    cfg(9'h005);
    @(posedge clock);
    flush_dyn <= 1'b1;
    flush_sta <= 1'b1;
    k = 0;
    repeat (6) begin
      @(posedge clock);
      #1;
      if (dyn_flush !== 3'h0 || sta_flush !== 3'h0) begin
        k++;
        chk({dyn_flush, sta_flush}, 6'h2D, "flush ports");
      end
    end
    chk(k, 1, "flush pulses");
    @(posedge clock);
    flush_sta <= 1'b0;
    cfg(9'h0DC);
    @(posedge clock);
    tail_tag_en <= 1'b1;
    @(posedge clock);
    for (int t = 0; t < 24; t++) host_frame(1 + t % 4, {t % 7 == 6, t % 5 == 2, 2'(t % 4), codes[t % 6], 1'(t)});
    host_frame(3, 8'h7E);
    settle();
    for (int s = 0; s < 8; s++) sw_frame(2'(s / 2), 1'(s), 2 + s % 3);
    cfg(9'h000);
    host_frame(2, 8'h0E);
    sw_frame(2'h2, 1'b0, 2);
    settle();
    @(posedge clock);
    tail_tag_en <= 1'b0;
    @(posedge clock);
    sw_frame(2'h0, 1'b0, 3);
    fab_hold <= 1'b1;
    repeat (3) @(posedge clock);
    host.fill(30, k);
    chk(k, rstpt_pkg::FIFO_DEPTH + 1, "buffer depth");
    for (int i = 0; i < k; i++) begin
      crc_run = crc_b(crc_run, 8'(i));
      fab_q.push_back({~crc_run, 6'h20, 1'b0, 8'(i)});
    end
    fab_hold <= 1'b0;
    host_frame(2, 8'h00);
    settle();
    stop_test();
  end
endmodule
